//--- design/ssw_defines.svh
/*
 * Constants of the supply supervisor: clock rate, hold and interval times,
 * register offsets, field positions and reset values.
 * Assumes a single 20 MHz clock and 8-bit APB byte addresses.
 */
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and times, in microseconds
// ----------------------------------------------------------------------
`define SSW_CLK_MHZ 20
`define SSW_POR0_US 50000
`define SSW_POR1_US 200000
`define SSW_POR2_US 400000
`define SSW_POR3_US 800000
`define SSW_WDT0_US 25000
`define SSW_WDT1_US 200000
`define SSW_WDT2_US 1400000
`define SSW_DB_US 1000

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SSW_ADDR_CTRL 8'h00
`define SSW_ADDR_STATE 8'h04
`define SSW_ADDR_IRQ_STAT 8'h08
`define SSW_ADDR_IRQ_CLR 8'h0C
`define SSW_ADDR_IRQ_EN 8'h10
`define SSW_CTRL_POR_LSB 0
`define SSW_CTRL_WDT_LSB 2
`define SSW_POR_SEL_RST 2'h0
`define SSW_WDT_SEL_RST 2'h0
`define SSW_WDT_OFF 2'h3
`define SSW_IRQ_EN_RST 4'h0

`endif

//--- design/ssw_pkg.sv
/*
 * Types of the supply supervisor: state enumerations and signal bundles.
 * Assumes nothing of its surroundings.
 */
package ssw_pkg;

    typedef enum logic [1:0] {SUP_ASSERT, SUP_HOLD, SUP_RUN} ssw_sup_state_t;

    typedef enum logic [1:0] {KICK_IDLE, KICK_FALL, KICK_STOP} ssw_kick_state_t;

    typedef struct packed {
        logic primary_low;
        logic below_batt;
        logic second_ok;
        logic sda;
        logic scl;
    } ssw_pins_t;

    typedef struct packed {
        logic second_fail;
        logic manual;
        logic primary_low;
        logic wdt_fault;
    } ssw_events_t;

endpackage : ssw_pkg

//--- design/ssw_debounce.sv
/*
 * Manual reset debouncer: two-stage synchroniser followed by a stability
 * counter. Assumes an asynchronous, bouncing active-low push button input.
 */
`timescale 1ns/1ps

module ssw_debounce #(
    parameter int unsigned DB_CYC = 20000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic raw_n,
    output logic clean_n
);

    logic meta;
    logic sync;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_clean_n;

    // The level must stay put for the full count; any bounce restarts it.
    always_comb begin
        next_cnt = cnt;
        next_clean_n = clean_n;
        if (sync == clean_n) begin
            next_cnt = '0;
        end else if (cnt >= DB_CYC - 1) begin
            next_clean_n = sync;
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b1;
            sync <= 1'b1;
            cnt <= '0;
            clean_n <= 1'b1;
        end else begin
            meta <= raw_n;
            sync <= meta;
            cnt <= next_cnt;
            clean_n <= next_clean_n;
        end
    end

    db_settle_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(clean_n) |-> $past(cnt) >= DB_CYC - 1 && $past(sync) == clean_n)
        else $error("debounced level changed before the input settled");

endmodule : ssw_debounce

//--- design/ssw_nv_cell.sv
/*
 * Non-volatile watchdog interval cell. It has its own initialisation reset,
 * which stands for the first programming of the part; the main supply
 * reset does not touch it, so the setting survives power cycles.
 */
`timescale 1ns/1ps
`include "ssw_defines.svh"

module ssw_nv_cell (
    input wire logic clk,
    input wire logic nv_init_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_data,
    output logic [1:0] value
);

    logic [1:0] next_value;

    always_comb begin
        next_value = wr_en ? wr_data : value;
    end

    always_ff @(posedge clk or negedge nv_init_n) begin
        if (!nv_init_n) begin
            value <= `SSW_WDT_SEL_RST;
        end else begin
            value <= next_value;
        end
    end

endmodule : ssw_nv_cell

//--- design/ssw_supervisor.sv
/*
 * Supply supervisor with watchdog, APB register slave and interrupt.
 * Assumes analog comparators deliver digital levels on asynchronous pins,
 * a host that restarts the watchdog on the two-wire pins, and an APB master.
 */
// Added by the designer: the APB interface to the registers and the address map.
// How it works
// - After power-up the reset output stays active for one of four hold times, 0.05 s to 0.8 s.
// - A low primary supply holds reset active until it recovers and the hold time has run.
// - If the host does not restart the watchdog within the interval, the fault output goes active.
// - The watchdog interval is 25 ms, 200 ms or 1.4 s, or the watchdog is off.
// - The watchdog interval is held in a non-volatile cell that survives supply loss.
// - The manual reset input is debounced before it can cause a reset.
// - The second supply fail output pulls low while the second monitor is below its trip level.
// - The early low supply output pulls low while the primary supply is below its trip level.
// - The battery is selected only when the primary is low and below the battery.
// - Manual reset holds reset active, and for the hold time after its release.
// - A falling data edge with clock high, then a falling clock edge, then a stop condition, in that order, restart the watchdog.
`timescale 1ns/1ps
`include "ssw_defines.svh"

module ssw_supervisor #(
    parameter int unsigned POR_CYC0 = `SSW_POR0_US * `SSW_CLK_MHZ,
    parameter int unsigned POR_CYC1 = `SSW_POR1_US * `SSW_CLK_MHZ,
    parameter int unsigned POR_CYC2 = `SSW_POR2_US * `SSW_CLK_MHZ,
    parameter int unsigned POR_CYC3 = `SSW_POR3_US * `SSW_CLK_MHZ,
    parameter int unsigned WDT_CYC0 = `SSW_WDT0_US * `SSW_CLK_MHZ,
    parameter int unsigned WDT_CYC1 = `SSW_WDT1_US * `SSW_CLK_MHZ,
    parameter int unsigned WDT_CYC2 = `SSW_WDT2_US * `SSW_CLK_MHZ,
    parameter int unsigned DB_CYC = `SSW_DB_US * `SSW_CLK_MHZ,
    parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic nv_init_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_low_in,
    input wire logic primary_below_batt_in,
    input wire logic second_supply_sense,
    input wire logic manual_reset_in_n,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sys_reset_oe,
    output logic watchdog_fault_out_oe,
    output logic second_supply_fail_out_oe,
    output logic early_low_supply_out_oe,
    output logic battery_selected_out,
    output logic irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ssw_pkg::ssw_pins_t pins_raw;
    ssw_pkg::ssw_pins_t pins_m;
    ssw_pkg::ssw_pins_t pins_q;
    ssw_pkg::ssw_pins_t pins_d;
    ssw_pkg::ssw_sup_state_t sup_state;
    ssw_pkg::ssw_sup_state_t next_sup_state;
    ssw_pkg::ssw_kick_state_t kick_state;
    ssw_pkg::ssw_kick_state_t next_kick_state;
    ssw_pkg::ssw_events_t events;
    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    logic [31:0] por_limit;
    logic [31:0] wdt_cnt;
    logic [31:0] next_wdt_cnt;
    logic [31:0] wdt_limit;
    logic [31:0] rd_word;
    logic [1:0] por_sel;
    logic [1:0] next_por_sel;
    logic [1:0] wdt_sel;
    logic [3:0] irq_status;
    logic [3:0] next_irq_status;
    logic [3:0] irq_en;
    logic [3:0] next_irq_en;
    logic [3:0] clr_mask;
    logic wdt_fault;
    logic next_wdt_fault;
    logic mr_clean_n;
    logic mr_active;
    logic mr_prev;
    logic cause;
    logic in_reset;
    logic wdt_on;
    logic kick;
    logic sda_fall;
    logic sda_rise;
    logic scl_fall;
    logic setup;
    logic wr;
    logic nv_wr;
    logic addr_hit;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pins_raw = '{primary_low: primary_low_in, below_batt: primary_below_batt_in,
                        second_ok: second_supply_sense, sda: sda_in, scl: scl_in};

    // Reset loads the idle pin levels, so that no false edge or fail
    // indication appears in the first cycles after reset.
    localparam ssw_pkg::ssw_pins_t PINS_IDLE = '{primary_low: 1'b0, below_batt: 1'b0,
        second_ok: 1'b1, sda: 1'b1, scl: 1'b1};

    // The third stage keeps the previous sample for edge detection, so the
    // first stage feeds nothing but the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_m <= PINS_IDLE;
            pins_q <= PINS_IDLE;
            pins_d <= PINS_IDLE;
        end else begin
            pins_m <= pins_raw;
            pins_q <= pins_m;
            pins_d <= pins_q;
        end
    end

    ssw_debounce #(
        .DB_CYC(DB_CYC)
    ) u_mr_db (
        .clk(pclk),
        .rstn(presetn),
        .raw_n(manual_reset_in_n),
        .clean_n(mr_clean_n)
    );

    ssw_nv_cell u_nv (
        .clk(pclk),
        .nv_init_n(nv_init_n),
        .wr_en(nv_wr),
        .wr_data(pwdata[`SSW_CTRL_WDT_LSB +: 2]),
        .value(wdt_sel)
    );

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    assign mr_active = ~mr_clean_n;
    assign cause = pins_q.primary_low | mr_active;
    assign in_reset = (sup_state != ssw_pkg::SUP_RUN);

    always_comb begin
        case (por_sel)
            2'h0: por_limit = POR_CYC0;
            2'h1: por_limit = POR_CYC1;
            2'h2: por_limit = POR_CYC2;
            default: por_limit = POR_CYC3;
        endcase
    end

    always_comb begin
        next_sup_state = sup_state;
        next_hold_cnt = hold_cnt;
        case (sup_state)
            ssw_pkg::SUP_ASSERT: begin
                if (!cause) begin
                    next_sup_state = ssw_pkg::SUP_HOLD;
                    next_hold_cnt = '0;
                end
            end
            ssw_pkg::SUP_HOLD: begin
                if (cause) begin
                    next_sup_state = ssw_pkg::SUP_ASSERT;
                end else if (hold_cnt >= por_limit - 32'h1) begin
                    next_sup_state = ssw_pkg::SUP_RUN;
                end else begin
                    next_hold_cnt = hold_cnt + 32'h1;
                end
            end
            ssw_pkg::SUP_RUN: begin
                if (cause) begin
                    next_sup_state = ssw_pkg::SUP_ASSERT;
                end
            end
            default: next_sup_state = ssw_pkg::SUP_ASSERT;
        endcase
    end

    // Reset itself is the power-on event, so it enters the hold directly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_state <= ssw_pkg::SUP_HOLD;
            hold_cnt <= '0;
        end else begin
            sup_state <= next_sup_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog restart detector
    // ------------------------------------------------------------------
    assign sda_fall = pins_d.sda & ~pins_q.sda;
    assign sda_rise = ~pins_d.sda & pins_q.sda;
    assign scl_fall = pins_d.scl & ~pins_q.scl;

    always_comb begin
        next_kick_state = kick_state;
        kick = 1'b0;
        case (kick_state)
            ssw_pkg::KICK_IDLE: begin
                if (sda_fall && pins_q.scl) begin
                    next_kick_state = ssw_pkg::KICK_FALL;
                end
            end
            ssw_pkg::KICK_FALL: begin
                if (scl_fall) begin
                    next_kick_state = ssw_pkg::KICK_STOP;
                end else if (sda_rise && pins_q.scl) begin
                    next_kick_state = ssw_pkg::KICK_IDLE;
                end
            end
            ssw_pkg::KICK_STOP: begin
                if (sda_rise && pins_q.scl) begin
                    next_kick_state = ssw_pkg::KICK_IDLE;
                    kick = 1'b1;
                end else if (sda_fall && pins_q.scl) begin
                    next_kick_state = ssw_pkg::KICK_FALL;
                end
            end
            default: next_kick_state = ssw_pkg::KICK_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kick_state <= ssw_pkg::KICK_IDLE;
        end else begin
            kick_state <= next_kick_state;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    assign wdt_on = (wdt_sel != `SSW_WDT_OFF);

    always_comb begin
        case (wdt_sel)
            2'h0: wdt_limit = WDT_CYC0;
            2'h1: wdt_limit = WDT_CYC1;
            default: wdt_limit = WDT_CYC2;
        endcase
    end

    // The counter also rests while the system is held in reset, because
    // the host cannot service it then.
    always_comb begin
        next_wdt_cnt = wdt_cnt;
        next_wdt_fault = wdt_fault;
        if (!wdt_on || in_reset || kick) begin
            next_wdt_cnt = '0;
            next_wdt_fault = 1'b0;
        end else if (wdt_cnt >= wdt_limit - 32'h1) begin
            next_wdt_fault = 1'b1;
        end else begin
            next_wdt_cnt = wdt_cnt + 32'h1;
        end
        // A new interval starts a fresh count, so a shorter one cannot leave
        // the counter beyond its end.
        if (nv_wr) begin
            next_wdt_cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt <= '0;
            wdt_fault <= 1'b0;
        end else begin
            wdt_cnt <= next_wdt_cnt;
            wdt_fault <= next_wdt_fault;
        end
    end

    // ------------------------------------------------------------------
    // APB slave and interrupt
    // ------------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign nv_wr = wr && (paddr == `SSW_ADDR_CTRL);
    assign addr_hit = (paddr == `SSW_ADDR_CTRL) || (paddr == `SSW_ADDR_STATE) ||
                      (paddr == `SSW_ADDR_IRQ_STAT) || (paddr == `SSW_ADDR_IRQ_CLR) ||
                      (paddr == `SSW_ADDR_IRQ_EN);
    assign events = '{second_fail: pins_d.second_ok & ~pins_q.second_ok,
                      manual: mr_active & ~mr_prev,
                      primary_low: pins_q.primary_low & ~pins_d.primary_low,
                      wdt_fault: next_wdt_fault & ~wdt_fault};

    always_comb begin
        case (paddr)
            `SSW_ADDR_CTRL: rd_word = {28'h0, wdt_sel, por_sel};
            `SSW_ADDR_STATE: rd_word = {26'h0, mr_active, battery_selected_out,
                                        ~pins_q.second_ok, pins_q.primary_low,
                                        wdt_fault, in_reset};
            `SSW_ADDR_IRQ_STAT: rd_word = {28'h0, irq_status};
            `SSW_ADDR_IRQ_EN: rd_word = {28'h0, irq_en};
            default: rd_word = 32'h0;
        endcase
    end

    // A clear in the same cycle as a new event loses to the event.
    always_comb begin
        clr_mask = (wr && paddr == `SSW_ADDR_IRQ_CLR) ? pwdata[3:0] : 4'h0;
        next_irq_status = (irq_status & ~clr_mask) | events;
        next_irq_en = (wr && paddr == `SSW_ADDR_IRQ_EN) ? pwdata[3:0] : irq_en;
        next_por_sel = (wr && paddr == `SSW_ADDR_CTRL) ?
                       pwdata[`SSW_CTRL_POR_LSB +: 2] : por_sel;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            por_sel <= `SSW_POR_SEL_RST;
            irq_status <= 4'h0;
            irq_en <= `SSW_IRQ_EN_RST;
            irq <= 1'b0;
        end else begin
            prdata <= (setup && !pwrite) ? rd_word : 32'h0;
            pready <= setup;
            pslverr <= setup && !addr_hit;
            por_sel <= next_por_sel;
            irq_status <= next_irq_status;
            irq_en <= next_irq_en;
            irq <= |(irq_status & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_oe <= ~RESET_ACTIVE_HIGH;
            watchdog_fault_out_oe <= 1'b0;
            second_supply_fail_out_oe <= 1'b0;
            early_low_supply_out_oe <= 1'b0;
            battery_selected_out <= 1'b0;
            mr_prev <= 1'b0;
        end else begin
            sys_reset_oe <= in_reset ^ RESET_ACTIVE_HIGH;
            watchdog_fault_out_oe <= wdt_fault;
            second_supply_fail_out_oe <= ~pins_q.second_ok;
            early_low_supply_out_oe <= pins_q.primary_low;
            battery_selected_out <= pins_q.primary_low & pins_q.below_batt;
            mr_prev <= mr_active;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence mr_release_s;
        mr_active ##1 !mr_active && !pins_q.primary_low;
    endsequence

    sequence kick_seen_s;
        kick && wdt_on && !in_reset;
    endsequence

    por_hold_a: assert property ($fell(in_reset) |->
        $past(sup_state) == ssw_pkg::SUP_HOLD && $past(hold_cnt) >= $past(por_limit) - 32'h1)
        else $error("reset released before the hold time ran");

    low_reset_a: assert property (pins_q.primary_low |=> in_reset ##1 sys_reset_oe ==
        ~RESET_ACTIVE_HIGH) else $error("low primary supply did not hold reset");

    wdt_fault_a: assert property (wdt_on && !in_reset && !kick &&
        wdt_cnt == wdt_limit - 32'h1 |=> wdt_fault ##1 watchdog_fault_out_oe)
        else $error("watchdog fault missed at interval end");

    wdt_limit_a: assert property (wdt_on |-> wdt_cnt < wdt_limit)
        else $error("watchdog counter ran past the interval");

    nv_keep_a: assert property (!nv_wr |=> $stable(wdt_sel))
        else $error("watchdog interval changed without a write");

    mr_hold_a: assert property (mr_release_s |-> in_reset ##1 in_reset && hold_cnt == 32'h0)
        else $error("manual reset release skipped the hold");

    v2_fail_a: assert property (!pins_q.second_ok |=> second_supply_fail_out_oe)
        else $error("second supply fail not driven");

    low_line_a: assert property (early_low_supply_out_oe == $past(pins_q.primary_low))
        else $error("early low supply output wrong");

    batt_sel_a: assert property (battery_selected_out ==
        ($past(pins_q.primary_low) && $past(pins_q.below_batt)))
        else $error("battery selection wrong");

    kick_restart_a: assert property (kick_seen_s |=> wdt_cnt == 32'h0 && !wdt_fault)
        else $error("restart did not clear the watchdog");

    reset_pol_a: assert property (sys_reset_oe == $past(in_reset ^ RESET_ACTIVE_HIGH))
        else $error("reset output polarity wrong");

    wdt_off_a: assert property (!wdt_on |=> wdt_cnt == 32'h0 && !wdt_fault
        ##1 !watchdog_fault_out_oe) else $error("watchdog active while off");

endmodule : ssw_supervisor

//--- bench/ssw_host_model.sv
/*
 * Host partner: plays the watchdog restart sequence on the two-wire pins.
 * Assumes pull-ups on both lines, so they idle high between restarts.
 */
`timescale 1ns/1ps

module ssw_host_model (
    input wire logic pclk,
    input wire logic kick,
    output logic sda,
    output logic scl
);
    int step = 0;

    initial begin
        sda = 1'b1;
        scl = 1'b1;
    end

    // Each phase lasts several clocks so that the pin synchronisers see it.
    always @(posedge pclk) begin
        if (step == 0) begin
            step <= kick ? 1 : 0;
        end else begin
            step <= (step == 20) ? 0 : step + 1;
        end
    end

    // Data falls with clock high, clock pulses low, then data rises with clock high.
    always @(posedge pclk) begin
        sda <= !(step >= 1 && step < 16);
        scl <= !(step >= 6 && step < 11);
    end
endmodule : ssw_host_model

//--- bench/tb.sv
/*
 * Self-checking testbench of the supply supervisor with shortened counts.
 * Assumes the active-low reset variant and the host partner model.
 */
`timescale 1ns/1ps

module tb;
    localparam int POR0 = 40;
    localparam int POR3 = 100;
    localparam int DB = 8;
    logic pclk, presetn, nv_init_n, psel, penable, pwrite, pready, pslverr, q_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic primary_low_in, primary_below_batt_in, second_supply_sense, manual_reset_in_n;
    logic sda, scl, kick, sys_reset_oe, wdt_oe, fail_oe, low_oe, batt, irq;
    int err_count = 0;
    int checks_done = 0;
    int c;
    int lim[3] = '{50, 80, 120};

    ssw_supervisor #(.POR_CYC0(POR0), .POR_CYC1(60), .POR_CYC2(80), .POR_CYC3(POR3),
        .WDT_CYC0(50), .WDT_CYC1(80), .WDT_CYC2(120), .DB_CYC(DB)) ssw_supervisor_inst (
        .pclk(pclk), .presetn(presetn), .nv_init_n(nv_init_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_low_in(primary_low_in), .primary_below_batt_in(primary_below_batt_in),
        .second_supply_sense(second_supply_sense), .manual_reset_in_n(manual_reset_in_n),
        .sda_in(sda), .scl_in(scl), .sys_reset_oe(sys_reset_oe),
        .watchdog_fault_out_oe(wdt_oe), .second_supply_fail_out_oe(fail_oe),
        .early_low_supply_out_oe(low_oe), .battery_selected_out(batt), .irq(irq));

    ssw_host_model ssw_host_model_inst (.pclk(pclk), .kick(kick), .sda(sda), .scl(scl));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wt(ref logic s, input logic v, input int n, output int cnt);
        cnt = 0;
        while (s !== v) begin
            @(posedge pclk);
            cnt++;
            if (cnt > n) begin
                err_count++;
                $display("CHECK FAILED at %0t: wait for output ran out", $time);
                end_of_test();
            end
        end
    endtask : wt

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            end_of_test();
        end
        q = prdata;
        q_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_kick();
        @(posedge pclk);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        repeat (23) @(posedge pclk);
    endtask : do_kick

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    initial begin
        {presetn, nv_init_n, psel, penable, pwrite, kick} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {primary_low_in, primary_below_batt_in} = 2'h0;
        {second_supply_sense, manual_reset_in_n} = 2'h3;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        nv_init_n <= 1'b1;
        wt(sys_reset_oe, 1'b0, POR0 + 10, c);
        chk(c >= POR0 && c <= POR0 + 8, 1'b1);
        second_supply_sense <= 1'b0;
        wt(fail_oe, 1'b1, 6, c);
        second_supply_sense <= 1'b1;
        wt(fail_oe, 1'b0, 6, c);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h00, 32'h3);
        primary_below_batt_in <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(batt, 1'b0);
        primary_low_in <= 1'b1;
        wt(sys_reset_oe, 1'b1, 6, c);
        chk(low_oe, 1'b1);
        chk(batt, 1'b1);
        wt(irq, 1'b1, 4, c);
        primary_below_batt_in <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(batt, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk(q[1], 1'b1);
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk(q[1], 1'b0);
        chk(irq, 1'b0);
        apb(1'b0, 8'h44, 32'h0);
        chk(q_err, 1'b1);
        primary_low_in <= 1'b0;
        wt(sys_reset_oe, 1'b0, POR3 + 10, c);
        chk(c >= POR3 && c <= POR3 + 8, 1'b1);
        chk(low_oe, 1'b0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 8'h00, i << 2);
            do_kick();
            chk(wdt_oe, 1'b0);
            repeat (lim[i] - 12) @(posedge pclk);
            chk(wdt_oe, 1'b0);
            wt(wdt_oe, 1'b1, 30, c);
        end
        apb(1'b1, 8'h00, 32'hC);
        wt(wdt_oe, 1'b0, 6, c);
        repeat (200) @(posedge pclk);
        chk(wdt_oe, 1'b0);
        // Bounces shorter than the settle time must not start a reset.
        repeat (4) begin
            manual_reset_in_n <= 1'b0;
            repeat (3) @(posedge pclk);
            manual_reset_in_n <= 1'b1;
            repeat (3) @(posedge pclk);
        end
        chk(sys_reset_oe, 1'b0);
        manual_reset_in_n <= 1'b0;
        wt(sys_reset_oe, 1'b1, DB + 8, c);
        repeat (30) @(posedge pclk);
        chk(sys_reset_oe, 1'b1);
        manual_reset_in_n <= 1'b1;
        wt(sys_reset_oe, 1'b0, POR0 + DB + 12, c);
        chk(c >= POR0 + DB, 1'b1);
        apb(1'b1, 8'h00, 32'h8);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h8);
        end_of_test();
    end
endmodule : tb
